// ### hw/gx_pkg.sv
/*
  Shared constants, register map and state types of the GPIO expander core:
  edge sensing, interrupt flags, bank level shifter, oscillator and clock out.
  Assumes a single 20 MHz core clock and a synchronous active-high reset.
*/
// Operation
// - Two-bit edge sense for IO3..IO0, low register
// - Same encoding for IO7..IO4, high register
// - Mask 0 allows interrupt, resets all blocked
// - Unmasked matching edge sets interrupt-source bit if its dir bit is 1
// - Write one to source clears source and event
// - Interrupt pin low while any source set
// - Matching edge sets event-status bit
// - Write one to event clears event and source
// - Autoclear 0: data read clears all sources
// - Two-bit level shifter mode per bank pair
// - Source 00 stops oscillator and engines
// - Source 01 external pin, 10 internal 2MHz
// - Clock bit 4 sets shared pin direction
// - Divider 0 holds low, F holds high
// - Other divider n outputs core_osc_freq over 2^(n-1)
// - Misc bit 7 picks bank B fade curve
package gx_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_POLARITY = 8'h06;
  localparam logic [7:0] ADDR_DIR = 8'h07;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h09;
  localparam logic [7:0] ADDR_SENSE_HI = 8'h0A;
  localparam logic [7:0] ADDR_SENSE_LO = 8'h0B;
  localparam logic [7:0] ADDR_SRC = 8'h0C;
  localparam logic [7:0] ADDR_EVT = 8'h0D;
  localparam logic [7:0] ADDR_SHIFTER = 8'h0E;
  localparam logic [7:0] ADDR_CLOCK = 8'h0F;
  localparam logic [7:0] ADDR_MISC = 8'h10;

  // Values after reset
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Field positions
  localparam int CLK_SRC_LSB = 5;
  localparam int CLK_PIN_DIR_BIT = 4;
  localparam int MISC_FADE_B_BIT = 7;
  localparam int MISC_NOINC_BIT = 1;
  localparam int MISC_MANUAL_CLR_BIT = 0;

  // Encodings
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;
  localparam logic [3:0] DIV_LOW = 4'h0;
  localparam logic [3:0] DIV_HIGH = 4'hF;

  // Bus address, arbitrary value
  localparam logic [6:0] I2C_DEV_ADDR = 7'h3E;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  // Timing: half period of the internal 2 MHz oscillator
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_HALF_NS = 250;
  localparam int OSC_HALF_CYC = (OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_CNT_W = 14;
  localparam logic [2:0] ARM_DONE = 3'h7;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_A = 9'h004,
    ST_REG = 9'h008,
    ST_ACK_R = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } gx_i2c_state_t;

  typedef struct packed {
    logic [7:0] polarity;
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] mask;
    logic [7:0] sense_hi;
    logic [7:0] sense_lo;
    logic [7:0] src;
    logic [7:0] evt;
    logic [7:0] shifter;
    logic [7:0] clock;
    logic [7:0] misc;
  } gx_regs_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
    logic [7:0] evt;
    logic [2:0] armed;
  } gx_edge_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [2:0] pre;
    logic [DIV_CNT_W-1:0] cnt;
    logic lvl;
  } gx_div_t;

endpackage

// ### hw/gx_edge_detect.sv
/*
  Per-IO edge detector: two-stage pin synchronizer, polarity inversion and
  edge match against the two-bit sense field of each IO.
  Assumes raw asynchronous pins and configuration from the core clock domain.
*/
`timescale 1ns/1ps
module gx_edge_detect import gx_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pins and configuration
  input wire logic [7:0] io_pins,
  input wire logic [7:0] polarity,
  input wire logic [15:0] sense,
  // Results
  output logic [7:0] level,
  output logic [7:0] events
);

  gx_edge_t q;
  gx_edge_t n;
  logic [7:0] adj;
  logic [7:0] hit;

  function automatic logic sense_hit(input logic [1:0] mode, input logic cur, input logic old);
    sense_hit = ((mode == SENSE_RISE || mode == SENSE_BOTH) && cur && !old) ||
                ((mode == SENSE_FALL || mode == SENSE_BOTH) && !cur && old);
  endfunction

  assign adj = q.s2 ^ polarity;

  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign hit[i] = sense_hit(sense[2*i+1 -: 2], adj[i], q.prev[i]);
  end

  always_comb begin
    n = q;
    n.s1 = io_pins;
    n.s2 = q.s1;
    n.prev = adj;
    n.armed = {q.armed[1:0], 1'h1};
    n.evt = (q.armed == ARM_DONE) ? hit : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level = q.prev;
  assign events = q.evt;

  property p_edge_seen;
    @(posedge ref_clk) disable iff (sys_rst)
      (q.armed == ARM_DONE && sense[1:0] == SENSE_RISE && adj[0] && !q.prev[0]) |=> events[0];
  endproperty
  a_edge_seen: assert property (p_edge_seen) else $error("rising edge on IO0 not reported");

endmodule

// ### hw/gx_clk_out.sv
/*
  Oscillator selection and clock-out divider: internal 2 MHz tick or the
  synchronized external clock, divided by a power of two, or a static level.
  Assumes the external clock is much slower than the 20 MHz core clock.
*/
`timescale 1ns/1ps
module gx_clk_out import gx_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic [1:0] osc_src,
  input wire logic ext_ok,
  input wire logic [3:0] div,
  // Pins
  input wire logic ext_clock_in,
  output logic clock_out_pin
);

  gx_div_t q;
  gx_div_t n;
  logic tick;
  logic wrap;
  logic [DIV_CNT_W-1:0] limit;

  always_comb begin
    limit = DIV_CNT_W'((15'h0001 << (div - 4'h1)) - 15'h0001);
    tick = 1'h0;
    if (osc_src == SRC_INT) begin
      tick = (q.pre == 3'(OSC_HALF_CYC - 1));
    end else if (osc_src == SRC_EXT && ext_ok) begin
      tick = (q.s2 != q.prev);
    end
    wrap = tick && (q.cnt >= limit);
  end

  always_comb begin
    n = q;
    n.s1 = ext_clock_in;
    n.s2 = q.s1;
    n.prev = q.s2;
    if (osc_src != SRC_INT || q.pre == 3'(OSC_HALF_CYC - 1)) begin
      n.pre = 3'h0;
    end else begin
      n.pre = q.pre + 3'h1;
    end
    if (div == DIV_LOW) begin
      n.lvl = 1'h0;
      n.cnt = '0;
    end else if (div == DIV_HIGH) begin
      n.lvl = 1'h1;
      n.cnt = '0;
    end else if (wrap) begin
      n.lvl = !q.lvl;
      n.cnt = '0;
    end else if (tick) begin
      n.cnt = q.cnt + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign clock_out_pin = q.lvl;

  property p_static_level;
    @(posedge ref_clk) disable iff (sys_rst)
      (div == DIV_LOW) |=> !clock_out_pin;
  endproperty
  a_static_level: assert property (p_static_level) else $error("clock out not held low");

  property p_static_high;
    @(posedge ref_clk) disable iff (sys_rst)
      (div == DIV_HIGH) |=> clock_out_pin;
  endproperty
  a_static_high: assert property (p_static_high) else $error("clock out not held high");

  property p_toggle_on_wrap;
    @(posedge ref_clk) disable iff (sys_rst)
      ($changed(clock_out_pin) && $past(div) != DIV_LOW && $past(div) != DIV_HIGH) |-> $past(wrap);
  endproperty
  a_toggle_on_wrap: assert property (p_toggle_on_wrap) else $error("clock out toggled off the divider");

endmodule

// ### hw/gx_gpio_core.sv
/*
  GPIO expander core: two-wire register slave, edge event and interrupt
  flags, bank level shifter modes, oscillator and clock-out control.
  Assumes pins arrive raw from outside; the bus and IO pins are synchronized here.
*/
`timescale 1ns/1ps
module gx_gpio_core import gx_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Two-wire host bus
  input wire logic scl_pin,
  input wire logic sda_rx,
  output logic sda_drv,
  output logic sda_oe,
  // IO pins
  input wire logic [7:0] io_pins,
  // Open-drain interrupt pin
  output logic irq_out_low_drv,
  output logic irq_out_low_oe,
  // Shared oscillator pin
  input wire logic osc_shared_pin_rx,
  output logic osc_shared_pin_drv,
  output logic osc_shared_pin_oe,
  // Configuration to IO cells and engines
  output gx_regs_t cfg,
  output logic feature_en
);

  typedef struct packed {
    gx_regs_t regs;
    gx_i2c_state_t st;
    logic scl_s1;
    logic scl_s2;
    logic scl_prev;
    logic sda_s1;
    logic sda_s2;
    logic sda_prev;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic bus_oe;
    logic pin_oe;
    logic irq_oe;
    logic osc_run;
    logic od_low;
  } gx_core_t;

  gx_core_t q;
  gx_core_t n;

  logic [7:0] io_level;
  logic [7:0] edge_evt;
  logic [7:0] set_src;
  logic [7:0] rd_byte;
  logic [7:0] ptr_inc;
  logic [7:0] src_drop;
  logic [7:0] evt_drop;
  logic [7:0] clr_src;
  logic [7:0] clr_evt;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr;
  logic load;
  logic autoclr;
  logic clk_level;

  ////////////////////////////////////////////////////////////////////////////
  // Edge sensing and clock out

  gx_edge_detect u_edge (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .io_pins(io_pins),
    .polarity(q.regs.polarity),
    .sense({q.regs.sense_hi, q.regs.sense_lo}),
    .level(io_level),
    .events(edge_evt)
  );

  gx_clk_out u_clk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .osc_src(q.regs.clock[CLK_SRC_LSB+1:CLK_SRC_LSB]),
    .ext_ok(!q.regs.clock[CLK_PIN_DIR_BIT]),
    .div(q.regs.clock[3:0]),
    .ext_clock_in(osc_shared_pin_rx),
    .clock_out_pin(clk_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read view

  function automatic logic [7:0] rd_mux(input gx_regs_t r, input logic [7:0] a, input logic [7:0] lvl);
    if (a == ADDR_POLARITY) begin
      rd_mux = r.polarity;
    end else if (a == ADDR_DIR) begin
      rd_mux = r.dir;
    end else if (a == ADDR_DATA) begin
      rd_mux = lvl;
    end else if (a == ADDR_MASK) begin
      rd_mux = r.mask;
    end else if (a == ADDR_SENSE_HI) begin
      rd_mux = r.sense_hi;
    end else if (a == ADDR_SENSE_LO) begin
      rd_mux = r.sense_lo;
    end else if (a == ADDR_SRC) begin
      rd_mux = r.src;
    end else if (a == ADDR_EVT) begin
      rd_mux = r.evt;
    end else if (a == ADDR_SHIFTER) begin
      rd_mux = r.shifter;
    end else if (a == ADDR_CLOCK) begin
      rd_mux = r.clock;
    end else if (a == ADDR_MISC) begin
      rd_mux = r.misc;
    end else begin
      rd_mux = 8'h00;
    end
  endfunction

  assign rd_byte = rd_mux(q.regs, q.ptr, io_level);
  assign ptr_inc = q.regs.misc[MISC_NOINC_BIT] ? q.ptr : q.ptr + 8'h01;
  assign set_src = edge_evt & ~q.regs.mask & q.regs.dir;
  assign src_drop = clr_src & ~set_src;
  assign evt_drop = clr_evt & ~edge_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = q;
    wr = 1'h0;
    load = 1'h0;
    autoclr = 1'h0;
    clr_src = 8'h00;
    clr_evt = 8'h00;
    n.scl_s1 = scl_pin;
    n.scl_s2 = q.scl_s1;
    n.scl_prev = q.scl_s2;
    n.sda_s1 = sda_rx;
    n.sda_s2 = q.sda_s1;
    n.sda_prev = q.sda_s2;
    scl_rise = q.scl_s2 && !q.scl_prev;
    scl_fall = !q.scl_s2 && q.scl_prev;
    bus_start = q.scl_s2 && q.scl_prev && q.sda_prev && !q.sda_s2;
    bus_stop = q.scl_s2 && q.scl_prev && !q.sda_prev && q.sda_s2;

    if (bus_start) begin
      n.st = ST_ADDR;
      n.cnt = 4'h0;
      n.bus_oe = 1'h0;
    end else if (bus_stop) begin
      n.st = ST_IDLE;
      n.bus_oe = 1'h0;
    end else if (scl_rise) begin
      if (q.st == ST_RACK) begin
        n.nack = q.sda_s2;
      end else if (q.cnt < I2C_BYTE_BITS && q.st != ST_IDLE) begin
        n.cnt = q.cnt + 4'h1;
        if (q.st != ST_RDATA) begin
          n.shift = {q.shift[6:0], q.sda_s2};
        end
      end
    end else if (scl_fall) begin
      case (q.st)
        ST_ADDR: begin
          if (q.cnt == I2C_BYTE_BITS) begin
            if (q.shift[7:1] == I2C_DEV_ADDR) begin
              n.rw = q.shift[0];
              n.bus_oe = 1'h1;
              n.st = ST_ACK_A;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          n.cnt = 4'h0;
          if (q.rw) begin
            load = 1'h1;
          end else begin
            n.bus_oe = 1'h0;
            n.st = ST_REG;
          end
        end
        ST_REG: begin
          if (q.cnt == I2C_BYTE_BITS) begin
            n.ptr = q.shift;
            n.bus_oe = 1'h1;
            n.st = ST_ACK_R;
          end
        end
        ST_ACK_R, ST_ACK_W: begin
          n.cnt = 4'h0;
          n.bus_oe = 1'h0;
          n.st = ST_WDATA;
        end
        ST_WDATA: begin
          if (q.cnt == I2C_BYTE_BITS) begin
            wr = 1'h1;
            n.ptr = ptr_inc;
            n.bus_oe = 1'h1;
            n.st = ST_ACK_W;
          end
        end
        ST_RDATA: begin
          if (q.cnt == I2C_BYTE_BITS) begin
            n.bus_oe = 1'h0;
            n.st = ST_RACK;
          end else begin
            n.shift = {q.shift[6:0], 1'h0};
            n.bus_oe = !q.shift[6];
          end
        end
        ST_RACK: begin
          if (q.nack) begin
            n.bus_oe = 1'h0;
            n.st = ST_IDLE;
          end else begin
            load = 1'h1;
          end
        end
        default: begin
          n.bus_oe = 1'h0;
        end
      endcase
    end

    if (load) begin
      n.shift = rd_byte;
      n.bus_oe = !rd_byte[7];
      n.cnt = 4'h0;
      n.ptr = ptr_inc;
      n.st = ST_RDATA;
      autoclr = (q.ptr == ADDR_DATA) && !q.regs.misc[MISC_MANUAL_CLR_BIT];
    end

    if (wr) begin
      if (q.ptr == ADDR_POLARITY) begin
        n.regs.polarity = q.shift;
      end else if (q.ptr == ADDR_DIR) begin
        n.regs.dir = q.shift;
      end else if (q.ptr == ADDR_DATA) begin
        n.regs.data = q.shift;
      end else if (q.ptr == ADDR_MASK) begin
        n.regs.mask = q.shift;
      end else if (q.ptr == ADDR_SENSE_HI) begin
        n.regs.sense_hi = q.shift;
      end else if (q.ptr == ADDR_SENSE_LO) begin
        n.regs.sense_lo = q.shift;
      end else if (q.ptr == ADDR_SRC) begin
        clr_src = q.shift;
        clr_evt = q.shift;
      end else if (q.ptr == ADDR_EVT) begin
        clr_evt = q.shift;
        clr_src = q.shift;
      end else if (q.ptr == ADDR_SHIFTER) begin
        n.regs.shifter = q.shift;
      end else if (q.ptr == ADDR_CLOCK) begin
        n.regs.clock = q.shift;
      end else if (q.ptr == ADDR_MISC) begin
        n.regs.misc = q.shift;
      end
    end
    if (autoclr) begin
      clr_src = 8'hFF;
    end

    // A new edge wins over a clear in the same cycle
    n.regs.src = (q.regs.src & ~clr_src) | set_src;
    n.regs.evt = (q.regs.evt & ~clr_evt) | edge_evt;
    n.irq_oe = |n.regs.src;
    n.pin_oe = n.regs.clock[CLK_PIN_DIR_BIT];
    n.osc_run = (n.regs.clock[CLK_SRC_LSB+1:CLK_SRC_LSB] == SRC_EXT) ||
                (n.regs.clock[CLK_SRC_LSB+1:CLK_SRC_LSB] == SRC_INT);
    n.od_low = 1'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.regs.dir <= RST_DIR;
      q.regs.data <= RST_DATA;
      q.regs.mask <= RST_MASK;
      q.scl_s1 <= 1'h1;
      q.scl_s2 <= 1'h1;
      q.scl_prev <= 1'h1;
      q.sda_s1 <= 1'h1;
      q.sda_s2 <= 1'h1;
      q.sda_prev <= 1'h1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sda_drv = q.od_low;
  assign sda_oe = q.bus_oe;
  assign irq_out_low_drv = q.od_low;
  assign irq_out_low_oe = q.irq_oe;
  assign osc_shared_pin_drv = clk_level;
  assign osc_shared_pin_oe = q.pin_oe;
  assign cfg = q.regs;
  assign feature_en = q.osc_run;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_irq_follows;
    @(posedge ref_clk) disable iff (sys_rst) irq_out_low_oe == (q.regs.src != RST_ZERO);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt pin not tracking sources");

  property p_evt_sets;
    @(posedge ref_clk) disable iff (sys_rst) (edge_evt != 8'h00) |=> ((q.regs.evt & $past(edge_evt)) == $past(edge_evt));
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("edge did not set event flag");

  property p_src_sets;
    @(posedge ref_clk) disable iff (sys_rst) (set_src != 8'h00) |=> ((q.regs.src & $past(set_src)) == $past(set_src));
  endproperty
  a_src_sets: assert property (p_src_sets) else $error("unmasked edge did not set source flag");

  property p_masked_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
      1'h1 |=> ((q.regs.src & ~$past(q.regs.src) & ($past(q.regs.mask) | ~$past(q.regs.dir))) == 8'h00);
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked IO raised a source flag");

  property p_src_w1c;
    @(posedge ref_clk) disable iff (sys_rst) (src_drop != 8'h00) |=> ((q.regs.src & $past(src_drop)) == 8'h00);
  endproperty
  a_src_w1c: assert property (p_src_w1c) else $error("source flag survived its clear");

  property p_evt_w1c;
    @(posedge ref_clk) disable iff (sys_rst) (evt_drop != 8'h00) |=> ((q.regs.evt & $past(evt_drop)) == 8'h00);
  endproperty
  a_evt_w1c: assert property (p_evt_w1c) else $error("event flag survived its clear");

  property p_autoclear;
    @(posedge ref_clk) disable iff (sys_rst) (autoclr && set_src == 8'h00) |=> (q.regs.src == 8'h00) && !irq_out_low_oe;
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("data read did not clear sources");

  property p_osc_off;
    @(posedge ref_clk) disable iff (sys_rst)
      (q.regs.clock[CLK_SRC_LSB+1:CLK_SRC_LSB] == SRC_OFF) [*2] |-> !feature_en;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("engines running with oscillator off");

  property p_pin_dir;
    @(posedge ref_clk) disable iff (sys_rst) ##1 osc_shared_pin_oe == $past(n.regs.clock[CLK_PIN_DIR_BIT]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("shared pin direction mismatch");

endmodule

// ### tb/gx_host_model.sv
/*
  Two-wire host model: drives the bus clock and pulls the data line low.
  Assumes the data line is pulled up and resolved in the testbench.
*/
`timescale 1ns/1ps
module gx_host_model import gx_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Bus
  input wire logic sda_line,
  output logic scl_pin,
  output logic sda_pull
);
  // Cycles per bus half phase; raise it to act as a slow host
  int ph = 5;

  initial begin
    scl_pin = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic half();
    repeat (ph) @(posedge ref_clk);
    #5;
  endtask

  task automatic start_cond();
    sda_pull = 1'b0;
    half();
    scl_pin = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl_pin = 1'b0;
    half();
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    half();
    scl_pin = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask

  // Data changes only while the clock is low
  task automatic xfer_bit(input logic b, output logic r);
    sda_pull = ~b;
    half();
    scl_pin = 1'b1;
    half();
    r = sda_line;
    scl_pin = 1'b0;
    half();
  endtask

  // Eight bits first to last, then a released ninth bit
  task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], q[i]);
    end
    xfer_bit(1'b1, nak);
  endtask
endmodule

// ### tb/tb.sv
/*
  Testbench of the GPIO expander core: register access over the two-wire bus,
  edge events, interrupt flags and clock-out control.
  Assumes the package and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb import gx_pkg::*; ();
  logic ref_clk, sys_rst, scl_pin, sda_pull, sda_line, sda_drv, sda_oe;
  logic irq_drv, irq_oe, osc_rx, osc_drv, osc_oe, ext_clk, feature_en;
  logic [7:0] io_pins;
  gx_regs_t cfg;
  int fails = 0;
  int compares = 0;

  assign sda_line = ~(sda_pull | sda_oe);
  assign osc_rx = osc_oe ? osc_drv : ext_clk;

  gx_gpio_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_rx(sda_line),
    .sda_drv(sda_drv), .sda_oe(sda_oe), .io_pins(io_pins), .irq_out_low_drv(irq_drv),
    .irq_out_low_oe(irq_oe), .osc_shared_pin_rx(osc_rx), .osc_shared_pin_drv(osc_drv),
    .osc_shared_pin_oe(osc_oe), .cfg(cfg), .feature_en(feature_en));
  gx_host_model u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl_pin(scl_pin), .sda_pull(sda_pull));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    ext_clk = 1'b0;
    forever #1000 ext_clk = ~ext_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic n;
    u_host.start_cond();
    u_host.xfer_byte({I2C_DEV_ADDR, 1'b0}, q, n);
    chk({7'h00, n}, 8'h00, "address ack");
    u_host.xfer_byte(a, q, n);
    u_host.xfer_byte(d, q, n);
    chk({7'h00, n}, 8'h00, "data ack");
    u_host.stop_cond();
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic n;
    u_host.start_cond();
    u_host.xfer_byte({I2C_DEV_ADDR, 1'b0}, q, n);
    u_host.xfer_byte(a, q, n);
    u_host.start_cond();
    u_host.xfer_byte({I2C_DEV_ADDR, 1'b1}, q, n);
    chk({7'h00, n}, 8'h00, "read address ack");
    u_host.xfer_byte(8'hFF, d, n);
    u_host.stop_cond();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    reg_rd(a, d);
    chk(d, exp, what);
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(posedge ref_clk);
    #5;
    io_pins = v;
    repeat (10) @(posedge ref_clk);
    #5;
  endtask

  task automatic count_tg(input int cyc, output int t);
    logic p;
    p = osc_drv;
    t = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      #5;
      if (osc_drv !== p) t++;
      p = osc_drv;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge ref_clk);
    fails++;
    $display("mismatch at %0t: run too long", $time);
    close_out();
  end

  initial begin
    logic [7:0] d;
    int t;
    int e;
    io_pins = 8'h00;
    sys_rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    #5;
    sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    // Reset values, read by a slow host
    u_host.ph = 9;
    rd_chk(ADDR_MASK, RST_MASK, "mask reset");
    for (int a = 11; a <= 16; a++) rd_chk(8'(a), 8'h00, "reset value");
    rd_chk(8'h20, 8'h00, "unmapped read");
    chk({7'h00, irq_oe}, 8'h00, "irq after reset");
    chk({6'h00, sda_drv, irq_drv}, 8'h00, "open drain levels");
    $display("test reset done");
    u_host.ph = 5;
    reg_wr(ADDR_SHIFTER, 8'hA5);
    rd_chk(ADDR_SHIFTER, 8'hA5, "shifter modes");
    reg_wr(ADDR_MISC, 8'h81);
    chk({7'h00, cfg.misc[MISC_FADE_B_BIT]}, 8'h01, "fade curve");
    $display("test registers done");
    // Every sense code on all eight IOs
    reg_wr(ADDR_MASK, 8'h00);
    for (int m = 0; m < 4; m++) begin
      reg_wr(ADDR_SENSE_LO, {4{2'(m)}});
      reg_wr(ADDR_SENSE_HI, {4{2'(m)}});
      rd_chk(ADDR_SENSE_LO, {4{2'(m)}}, "sense readback");
      set_pins(8'hFF);
      chk(cfg.evt, m[0] ? 8'hFF : 8'h00, "rise event");
      chk(cfg.src, m[0] ? 8'hFF : 8'h00, "rise source");
      chk({7'h00, irq_oe}, {7'h00, m[0]}, "irq on rise");
      reg_wr(ADDR_EVT, 8'hFF);
      chk(cfg.src, 8'h00, "event clear");
      set_pins(8'h00);
      chk(cfg.evt, m[1] ? 8'hFF : 8'h00, "fall event");
      reg_wr(ADDR_SRC, 8'hFF);
      chk(cfg.evt, 8'h00, "source clear");
      chk({7'h00, irq_oe}, 8'h00, "irq released");
    end
    $display("test edges done");
    reg_wr(ADDR_MASK, 8'hF0);
    set_pins(8'hFF);
    chk(cfg.evt, 8'hFF, "masked events");
    chk(cfg.src, 8'h0F, "masked sources");
    reg_wr(ADDR_SRC, 8'h01);
    chk(cfg.src, 8'h0E, "one source cleared");
    chk({7'h00, irq_oe}, 8'h01, "irq held");
    reg_wr(ADDR_SRC, 8'h0E);
    chk(cfg.evt, 8'hF0, "events follow source clear");
    chk({7'h00, irq_oe}, 8'h00, "irq after last clear");
    reg_wr(ADDR_EVT, 8'h00);
    chk(cfg.evt, 8'hF0, "zero write keeps events");
    $display("test mask done");
    reg_wr(ADDR_MASK, 8'h00);
    set_pins(8'h00);
    reg_rd(ADDR_DATA, d);
    chk(d, 8'h00, "data read");
    chk(cfg.src, 8'hFF, "manual clear kept");
    reg_wr(ADDR_MISC, 8'h80);
    reg_rd(ADDR_DATA, d);
    chk(cfg.src, 8'h00, "autoclear on read");
    chk({7'h00, irq_oe}, 8'h00, "irq after autoclear");
    $display("test autoclear done");
    // Oscillator source codes, pin left as input
    for (int s = 0; s < 4; s++) begin
      reg_wr(ADDR_CLOCK, {1'b0, 2'(s), 5'h00});
      chk({6'h00, feature_en, osc_oe}, {6'h00, s == 1 || s == 2, 1'b0}, "source code");
    end
    reg_wr(ADDR_CLOCK, 8'h00);
    chk({7'h00, feature_en}, 8'h00, "oscillator off");
    reg_wr(ADDR_CLOCK, 8'h50);
    count_tg(40, t);
    chk({6'h00, osc_oe, osc_drv}, 8'h02, "static low");
    chk(8'(t), 8'h00, "low holds");
    reg_wr(ADDR_CLOCK, 8'h5F);
    chk({6'h00, osc_oe, osc_drv}, 8'h03, "static high");
    for (int n = 1; n < 4; n++) begin
      reg_wr(ADDR_CLOCK, 8'h50 | 8'(n));
      count_tg(400, t);
      e = 80 >> (n - 1);
      chk({7'h00, t >= e - 1 && t <= e + 1}, 8'h01, "divided clock");
    end
    // External source, pin as input, divider 1
    reg_wr(ADDR_CLOCK, 8'h21);
    count_tg(400, t);
    chk({7'h00, t >= 19 && t <= 21}, 8'h01, "external clock");
    $display("test clock done");
    close_out();
  end
endmodule
